// ---- logic/cmbse_cfg.svh ----
// Constants of the multiply, branch and skip execution unit
`ifndef CMBSE_CFG_SVH
`define CMBSE_CFG_SVH

// Status flag positions
`define CMBSE_FLAG_C 0
`define CMBSE_FLAG_Z 1
`define CMBSE_FLAG_N 2
`define CMBSE_FLAG_V 3
`define CMBSE_FLAG_S 4
`define CMBSE_FLAG_H 5
`define CMBSE_FLAG_T 6
`define CMBSE_FLAG_I 7

// Cycle counts
`define CMBSE_CYC_ONE 3'h1
`define CMBSE_CYC_MUL 3'h2
`define CMBSE_CYC_POINTER_JUMP 3'h2
`define CMBSE_CYC_RELATIVE_INVOKE 3'h3
`define CMBSE_CYC_JMP 3'h3
`define CMBSE_CYC_CALL 3'h4
`define CMBSE_CYC_TAKEN 3'h2
`define CMBSE_CYC_SKIP1 3'h2
`define CMBSE_CYC_SKIP2 3'h3

// Register offsets (byte addresses)
`define CMBSE_REG_CTRL 8'h00
`define CMBSE_REG_STATUS 8'h04
`define CMBSE_REG_COUNT 8'h08

// Field positions and reset values
`define CMBSE_CTRL_EN 0
`define CMBSE_STAT_BUSY 0
`define CMBSE_STAT_ILLEGAL 1
`define CMBSE_CTRL_RESET 1'h1

`endif

// ---- logic/cmbse_pkg.sv ----
// Types of the multiply, branch and skip execution unit
package cmbse_pkg;
   typedef enum logic [5:0] {
      OP_SELF_AND_TEST,
      OP_UNSIGNED_PRODUCT,
      OP_SIGNED_PRODUCT,
      OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_UNSIGNED_PRODUCT,
      OP_FRACTIONAL_SIGNED_PRODUCT,
      OP_FRACTIONAL_MIXED_PRODUCT,
      OP_POINTER_JUMP,
      OP_ABSOLUTE_JUMP,
      OP_RELATIVE_INVOKE,
      OP_ABSOLUTE_INVOKE,
      OP_COMPARE_SKIP_EQUAL,
      OP_COMPARE,
      OP_COMPARE_CARRY,
      OP_COMPARE_IMMEDIATE,
      OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR,
      OP_SKIP_IO_BIT_SET,
      OP_BRANCH_FLAG_SET,
      OP_BRANCH_FLAG_CLEAR,
      OP_BRANCH_SIGNED_GE,
      OP_BRANCH_SIGNED_LESS,
      OP_BRANCH_UNSIGNED_GE,
      OP_BRANCH_UNSIGNED_LESS,
      OP_BRANCH_HALFCARRY_SET,
      OP_BRANCH_HALFCARRY_CLEAR,
      OP_BRANCH_IRQ_ON,
      OP_BRANCH_IRQ_OFF,
      OP_BRANCH_OVERFLOW_SET,
      OP_BRANCH_OVERFLOW_CLEAR,
      OP_BRANCH_TRANSFER_SET,
      OP_BRANCH_TRANSFER_CLEAR,
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_CARRY_CLEAR
   } cmbse_op_e;
endpackage

// ---- logic/cmbse_core.sv ----
// Execution unit for test, multiplies, jumps, calls, compares, skips and flag branches
//
// Behaviour
// [RULE1] Test: AND with itself, Z N V, 1 cycle
// [RULE2] Integer multiplies write R1:R0, Z C, 2 cycles
// [RULE3] Fractional multiplies shift product left one bit
// [RULE4] Pointer jump loads PC from Z, 2 cycles
// [RULE5] Relative invoke: PC plus offset plus one, 3 cycles
// [RULE6] Absolute invoke 4 cycles, jump 3, large variants
// [RULE7] Compare-skip-equal skips on match, 1/2/3 cycles
// [RULE8] Compares set Z N V C H, no store
// [RULE9] Register bit skips test selected bit value
// [RULE10] I/O bit skips test selected bit value
// [RULE11] Generic flag branches on selected flag state
// [RULE12] Signed ge branch when N xor V zero
// [RULE13] Signed less branch when N xor V one
// [RULE14] Unsigned branches test carry clear or set
// [RULE15] Half-carry branches test H set or clear
// [RULE16] Interrupt branches test global enable flag
// [RULE17] Overflow branches test V set or clear
// [RULE18] Transfer branches test T set or clear
// [RULE19] Carry branches test C, flags unchanged
// [RULE20] Skip 1/2/3 cycles, branch 1/2 cycles
`include "cmbse_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cmbse_core
   import cmbse_pkg::*;
#(
   parameter int PC_W = 16,
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic issue_valid,
   input wire cmbse_op_e issue_op,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rr_val,
   input wire logic [7:0] io_val,
   input wire logic [2:0] bit_sel,
   input wire logic [PC_W-1:0] imm,
   input wire logic [PC_W-1:0] pc_in,
   input wire logic [15:0] z_ptr,
   input wire logic [7:0] sreg_in,
   input wire logic next_two_word,
   output logic issue_ready,
   output logic done,
   output logic [PC_W-1:0] next_pc,
   output logic [15:0] pair_result,
   output logic pair_wr,
   output logic [7:0] sreg_out,
   output logic sreg_wr,
   output logic [PC_W-1:0] push_addr,
   output logic push_valid,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr
);
   logic ctrl_en;
   logic illegal;
   logic busy;
   logic [2:0] cnt;
   logic [31:0] retired;
   logic accept;
   logic commit;
   // Values computed at issue
   logic [2:0] c_cyc;
   logic [PC_W-1:0] c_pc;
   logic [15:0] c_pair;
   logic c_pair_wr;
   logic [7:0] c_sreg;
   logic c_sreg_wr;
   logic c_push;
   logic [PC_W-1:0] c_push_addr;
   logic c_illegal;
   // Values held while a multi-cycle op runs
   logic [PC_W-1:0] p_pc;
   logic [15:0] p_pair;
   logic p_pair_wr;
   logic [7:0] p_sreg;
   logic p_sreg_wr;
   logic p_push;
   logic [PC_W-1:0] p_push_addr;
   // Datapath helpers
   logic sign_a;
   logic sign_b;
   logic frac;
   logic signed [17:0] prod_full;
   logic [15:0] prod;
   logic [7:0] cmp_b;
   logic cmp_cin;
   logic [7:0] diff;
   logic skip;
   logic br_cond;
   logic is_branch;
   logic is_skip;
   logic [PC_W-1:0] pc_plus1;

   assign accept = issue_valid && issue_ready;
   assign commit = accept ? (c_cyc == `CMBSE_CYC_ONE) : (busy && cnt == 3'h1);
   assign pc_plus1 = pc_in + PC_W'(1);

   // Multiplier operand signedness; product is taken from the low 16 bits
   always_comb begin
      sign_a = issue_op inside {OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
                                OP_FRACTIONAL_MIXED_PRODUCT};
      sign_b = issue_op inside {OP_SIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT};
      frac = issue_op inside {OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
                              OP_FRACTIONAL_MIXED_PRODUCT};
      prod_full = $signed({sign_a & rd_val[7], rd_val}) * $signed({sign_b & rr_val[7], rr_val}); // RULE2
      prod = frac ? {prod_full[14:0], 1'b0} : prod_full[15:0]; // RULE3
   end

   // Compare subtractor, shared by the three compare forms
   always_comb begin
      cmp_b = rr_val;
      cmp_cin = (issue_op == OP_COMPARE_CARRY) ? sreg_in[`CMBSE_FLAG_C] : 1'b0;
      diff = rd_val - cmp_b - {7'h00, cmp_cin}; // RULE8
   end

   // Skip and branch conditions
   always_comb begin
      is_skip = 1'b1;
      skip = 1'b0;
      unique case (issue_op)
         OP_COMPARE_SKIP_EQUAL: skip = (rd_val == rr_val); // RULE7
         OP_SKIP_REG_BIT_CLEAR: skip = !rr_val[bit_sel]; // RULE9
         OP_SKIP_REG_BIT_SET: skip = rr_val[bit_sel]; // RULE9
         OP_SKIP_IO_BIT_CLEAR: skip = !io_val[bit_sel]; // RULE10
         OP_SKIP_IO_BIT_SET: skip = io_val[bit_sel]; // RULE10
         default: is_skip = 1'b0;
      endcase
      is_branch = 1'b1;
      br_cond = 1'b0;
      unique case (issue_op)
         OP_BRANCH_FLAG_SET: br_cond = sreg_in[bit_sel]; // RULE11
         OP_BRANCH_FLAG_CLEAR: br_cond = !sreg_in[bit_sel]; // RULE11
         OP_BRANCH_SIGNED_GE: br_cond = !(sreg_in[`CMBSE_FLAG_N] ^ sreg_in[`CMBSE_FLAG_V]); // RULE12
         OP_BRANCH_SIGNED_LESS: br_cond = sreg_in[`CMBSE_FLAG_N] ^ sreg_in[`CMBSE_FLAG_V]; // RULE13
         OP_BRANCH_UNSIGNED_GE: br_cond = !sreg_in[`CMBSE_FLAG_C]; // RULE14
         OP_BRANCH_UNSIGNED_LESS: br_cond = sreg_in[`CMBSE_FLAG_C]; // RULE14
         OP_BRANCH_HALFCARRY_SET: br_cond = sreg_in[`CMBSE_FLAG_H]; // RULE15
         OP_BRANCH_HALFCARRY_CLEAR: br_cond = !sreg_in[`CMBSE_FLAG_H]; // RULE15
         OP_BRANCH_IRQ_ON: br_cond = sreg_in[`CMBSE_FLAG_I]; // RULE16
         OP_BRANCH_IRQ_OFF: br_cond = !sreg_in[`CMBSE_FLAG_I]; // RULE16
         OP_BRANCH_OVERFLOW_SET: br_cond = sreg_in[`CMBSE_FLAG_V]; // RULE17
         OP_BRANCH_OVERFLOW_CLEAR: br_cond = !sreg_in[`CMBSE_FLAG_V]; // RULE17
         OP_BRANCH_TRANSFER_SET: br_cond = sreg_in[`CMBSE_FLAG_T]; // RULE18
         OP_BRANCH_TRANSFER_CLEAR: br_cond = !sreg_in[`CMBSE_FLAG_T]; // RULE18
         OP_BRANCH_CARRY_SET: br_cond = sreg_in[`CMBSE_FLAG_C]; // RULE19
         OP_BRANCH_CARRY_CLEAR: br_cond = !sreg_in[`CMBSE_FLAG_C]; // RULE19
         default: is_branch = 1'b0;
      endcase
   end

   // Result, flags, target and cycle count of the issued op
   always_comb begin
      c_cyc = `CMBSE_CYC_ONE;
      c_pc = pc_plus1;
      c_pair = prod;
      c_pair_wr = 1'b0;
      c_sreg = sreg_in;
      c_sreg_wr = 1'b0;
      c_push = 1'b0;
      c_push_addr = pc_plus1;
      c_illegal = 1'b0;
      if (is_skip) begin
         // Skipped length decides the extra cycles
         c_cyc = !skip ? `CMBSE_CYC_ONE : (next_two_word ? `CMBSE_CYC_SKIP2 : `CMBSE_CYC_SKIP1); // RULE20
         c_pc = pc_in + (!skip ? PC_W'(1) : (next_two_word ? PC_W'(3) : PC_W'(2))); // RULE7
      end else if (is_branch) begin
         c_cyc = br_cond ? `CMBSE_CYC_TAKEN : `CMBSE_CYC_ONE; // RULE20
         c_pc = br_cond ? pc_in + imm + PC_W'(1) : pc_plus1; // RULE11
      end else begin
         unique case (issue_op)
            OP_SELF_AND_TEST: begin
               c_sreg[`CMBSE_FLAG_Z] = (rd_val & rd_val) == 8'h00; // RULE1
               c_sreg[`CMBSE_FLAG_N] = rd_val[7]; // RULE1
               c_sreg[`CMBSE_FLAG_V] = 1'b0; // RULE1
               c_sreg_wr = 1'b1;
            end
            OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_UNSIGNED_PRODUCT,
            OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT: begin
               c_cyc = `CMBSE_CYC_MUL; // RULE2
               c_pair_wr = 1'b1;
               c_sreg[`CMBSE_FLAG_Z] = (prod == 16'h0000); // RULE3
               c_sreg[`CMBSE_FLAG_C] = prod_full[15]; // RULE3
               c_sreg_wr = 1'b1;
            end
            OP_POINTER_JUMP: begin
               c_cyc = `CMBSE_CYC_POINTER_JUMP; // RULE4
               c_pc = PC_W'(z_ptr); // RULE4
            end
            OP_RELATIVE_INVOKE: begin
               c_cyc = `CMBSE_CYC_RELATIVE_INVOKE; // RULE5
               c_pc = pc_in + imm + PC_W'(1); // RULE5
               c_push = 1'b1;
            end
            OP_ABSOLUTE_JUMP, OP_ABSOLUTE_INVOKE: begin
               // Small variants lack these; they step over the two words and flag it
               c_illegal = !LARGE_VARIANT; // RULE6
               c_cyc = (issue_op == OP_ABSOLUTE_INVOKE) ? `CMBSE_CYC_CALL : `CMBSE_CYC_JMP; // RULE6
               c_pc = LARGE_VARIANT ? imm : pc_in + PC_W'(2); // RULE6
               c_push = LARGE_VARIANT && issue_op == OP_ABSOLUTE_INVOKE;
               c_push_addr = pc_in + PC_W'(2);
            end
            OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMMEDIATE: begin
               c_sreg[`CMBSE_FLAG_H] = (!rd_val[3] & cmp_b[3]) | (cmp_b[3] & diff[3]) | (diff[3] & !rd_val[3]);
               c_sreg[`CMBSE_FLAG_V] = (rd_val[7] & !cmp_b[7] & !diff[7]) | (!rd_val[7] & cmp_b[7] & diff[7]);
               c_sreg[`CMBSE_FLAG_N] = diff[7];
               c_sreg[`CMBSE_FLAG_C] = (!rd_val[7] & cmp_b[7]) | (cmp_b[7] & diff[7]) | (diff[7] & !rd_val[7]);
               // With carry, zero only survives a chain that was zero so far
               c_sreg[`CMBSE_FLAG_Z] = (diff == 8'h00) &&
                  (issue_op != OP_COMPARE_CARRY || sreg_in[`CMBSE_FLAG_Z]); // RULE8
               c_sreg_wr = 1'b1;
            end
            default: c_cyc = `CMBSE_CYC_ONE;
         endcase
      end
   end

   // Sequencer: counts the op's remaining cycles
   always_ff @(posedge clock) begin
      if (reset) begin
         busy <= 1'b0;
         cnt <= 3'h0;
      end else if (accept && c_cyc != `CMBSE_CYC_ONE) begin
         busy <= 1'b1;
         cnt <= c_cyc - 3'h1; // RULE20
      end else if (busy) begin
         cnt <= cnt - 3'h1;
         busy <= (cnt != 3'h1);
      end
   end

   // Ready is a flop, so it looks one cycle ahead at the sequencer
   always_ff @(posedge clock) begin
      if (reset) begin
         issue_ready <= 1'b0;
      end else begin
         issue_ready <= ctrl_en && !(accept && c_cyc != `CMBSE_CYC_ONE) && !(busy && cnt != 3'h1);
      end
   end

   // Hold the results until the last cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         p_pc <= '0;
         p_pair <= 16'h0000;
         p_pair_wr <= 1'b0;
         p_sreg <= 8'h00;
         p_sreg_wr <= 1'b0;
         p_push <= 1'b0;
         p_push_addr <= '0;
      end else if (accept) begin
         p_pc <= c_pc;
         p_pair <= c_pair;
         p_pair_wr <= c_pair_wr;
         p_sreg <= c_sreg;
         p_sreg_wr <= c_sreg_wr;
         p_push <= c_push;
         p_push_addr <= c_push_addr;
      end
   end

   // Outputs change only on the commit cycle; strobes last one cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         done <= 1'b0;
         next_pc <= '0;
         pair_result <= 16'h0000;
         pair_wr <= 1'b0;
         sreg_out <= 8'h00;
         sreg_wr <= 1'b0;
         push_addr <= '0;
         push_valid <= 1'b0;
      end else begin
         done <= commit;
         pair_wr <= commit && (accept ? c_pair_wr : p_pair_wr);
         sreg_wr <= commit && (accept ? c_sreg_wr : p_sreg_wr);
         push_valid <= commit && (accept ? c_push : p_push);
         if (commit) begin
            next_pc <= accept ? c_pc : p_pc;
            pair_result <= accept ? c_pair : p_pair;
            sreg_out <= accept ? c_sreg : p_sreg;
            push_addr <= accept ? c_push_addr : p_push_addr;
         end
      end
   end

   // Software-visible state: enable, sticky illegal flag, retired count
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_en <= `CMBSE_CTRL_RESET;
         illegal <= 1'b0;
         retired <= 32'h00000000;
      end else begin
         // Writes land on the edge that completes the access, as pready is seen high
         if (psel && penable && pready && pwrite && paddr == `CMBSE_REG_CTRL) begin
            ctrl_en <= pwdata[`CMBSE_CTRL_EN];
         end
         // A new illegal op wins over a clear in the same cycle
         if (accept && c_illegal) begin
            illegal <= 1'b1;
         end else if (psel && penable && pready && pwrite && paddr == `CMBSE_REG_STATUS &&
                      pwdata[`CMBSE_STAT_ILLEGAL]) begin
            illegal <= 1'b0;
         end
         if (done) begin
            retired <= retired + 32'h00000001;
         end
      end
   end

   // APB slave: one wait state, then registered answer
   always_ff @(posedge clock) begin
      if (reset) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         if (psel && penable && !pready) begin
            unique case (paddr)
               `CMBSE_REG_CTRL: prdata <= {31'h00000000, ctrl_en};
               `CMBSE_REG_STATUS: prdata <= {30'h00000000, illegal, busy};
               `CMBSE_REG_COUNT: prdata <= pwrite ? 32'h00000000 : retired;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence s_acc(cmbse_op_e op);
      accept && issue_op == op;
   endsequence
   sequence s_two_cycle;
      !done ##1 done;
   endsequence

   a_test_flags: assert property (s_acc(OP_SELF_AND_TEST) |=> done && sreg_wr && // RULE1
      sreg_out[`CMBSE_FLAG_Z] == ($past(rd_val) == 8'h00) && !sreg_out[`CMBSE_FLAG_V])
      else $error("test op flags or timing wrong");
   a_mul_product: assert property (s_acc(OP_UNSIGNED_PRODUCT) |=> s_two_cycle ##0 // RULE2
      pair_wr && pair_result == {8'h00, $past(rd_val, 2)} * {8'h00, $past(rr_val, 2)})
      else $error("unsigned product wrong");
   a_frac_shift: assert property (s_acc(OP_FRACTIONAL_UNSIGNED_PRODUCT) |=> s_two_cycle ##0 // RULE3
      pair_result == 16'(({8'h00, $past(rd_val, 2)} * {8'h00, $past(rr_val, 2)}) << 1))
      else $error("fractional product wrong");
   a_ptr_jump: assert property (s_acc(OP_POINTER_JUMP) |=> s_two_cycle ##0 // RULE4
      next_pc == PC_W'($past(z_ptr, 2)) && !sreg_wr)
      else $error("pointer jump wrong");
   a_rel_invoke: assert property (s_acc(OP_RELATIVE_INVOKE) |=> !done [*2] ##1 // RULE5
      done && push_valid && next_pc == $past(pc_in, 3) + $past(imm, 3) + PC_W'(1))
      else $error("relative invoke wrong");
   a_abs_invoke: assert property (s_acc(OP_ABSOLUTE_INVOKE) ##0 LARGE_VARIANT |=> // RULE6
      !done [*3] ##1 done && next_pc == $past(imm, 4))
      else $error("absolute invoke wrong");
   a_skip_eq_two: assert property (s_acc(OP_COMPARE_SKIP_EQUAL) ##0 (rd_val == rr_val && next_two_word) // RULE7
      |=> !done [*2] ##1 done && next_pc == $past(pc_in, 3) + PC_W'(3))
      else $error("compare skip two-word wrong");
   a_cmp_zero: assert property (s_acc(OP_COMPARE) |=> done && sreg_wr && // RULE8
      sreg_out[`CMBSE_FLAG_Z] == ($past(rd_val) == $past(rr_val)))
      else $error("compare zero flag wrong");
   a_skip_bit_no: assert property (s_acc(OP_SKIP_REG_BIT_SET) ##0 !rr_val[bit_sel] // RULE9
      |=> done && next_pc == $past(pc_in) + PC_W'(1))
      else $error("register bit skip wrong");
   a_skip_io_one: assert property (s_acc(OP_SKIP_IO_BIT_CLEAR) ##0 (!io_val[bit_sel] && !next_two_word) // RULE10
      |=> s_two_cycle ##0 next_pc == $past(pc_in, 2) + PC_W'(2))
      else $error("io bit skip wrong");
   a_branch_ge: assert property (s_acc(OP_BRANCH_SIGNED_GE) ##0 // RULE12
      (sreg_in[`CMBSE_FLAG_N] == sreg_in[`CMBSE_FLAG_V]) |=> s_two_cycle ##0
      next_pc == $past(pc_in, 2) + $past(imm, 2) + PC_W'(1))
      else $error("signed ge branch wrong");
   a_branch_untaken: assert property (accept && is_branch && !br_cond // RULE20
      |=> done && !sreg_wr && next_pc == $past(pc_in) + PC_W'(1))
      else $error("untaken branch wrong");

endmodule // cmbse_core

`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench of the multiply, branch and skip execution unit
`timescale 1ns/1ps
`default_nettype none
`include "cmbse_cfg.svh"

module tb;
   import cmbse_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic issue_valid = 1'b0;
   cmbse_op_e issue_op = OP_SELF_AND_TEST;
   logic [7:0] rd_val = 8'h00, rr_val = 8'h00, io_val = 8'h00, sreg_in = 8'h00, paddr = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [15:0] imm = 16'h0000, pc_in = 16'h0000, z_ptr = 16'h0000;
   logic next_two_word = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rdata;
   logic issue_ready, done, pair_wr, sreg_wr, push_valid, pready, pslverr, rerr;
   logic [15:0] next_pc, pair_result, push_addr;
   logic [7:0] sreg_out;
   int err_total = 0, cmp_count = 0, n_ops = 0, cyc = 0;

   cmbse_core #(.PC_W(16), .LARGE_VARIANT(1'b1)) cmbse_core_i (.clock(clock), .reset(reset),
      .issue_valid(issue_valid), .issue_op(issue_op), .rd_val(rd_val), .rr_val(rr_val), .io_val(io_val),
      .bit_sel(bit_sel), .imm(imm), .pc_in(pc_in), .z_ptr(z_ptr), .sreg_in(sreg_in),
      .next_two_word(next_two_word), .issue_ready(issue_ready), .done(done), .next_pc(next_pc),
      .pair_result(pair_result), .pair_wr(pair_wr), .sreg_out(sreg_out), .sreg_wr(sreg_wr),
      .push_addr(push_addr), .push_valid(push_valid), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

   // 10 MHz clock
   always #50 clock = ~clock;

   // Hang guard: the whole run needs well under this many cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         summarize();
      end
   end

   task automatic summarize();
      if (err_total == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Offers one op, then times it; strobes are {pair_wr, sreg_wr, push_valid} seen with done
   task automatic run_op(input cmbse_op_e op, input int cycles, input logic [15:0] exp_pc, input logic [2:0] stb);
      int n;
      n = 1;
      while (issue_ready !== 1'b1) @(posedge clock) #1;
      @(posedge clock);
      issue_valid <= 1'b1;
      issue_op <= op;
      @(posedge clock);
      issue_valid <= 1'b0;
      #1;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clock) #1;
         n++;
      end
      n_ops++;
      check(n, cycles);
      check(next_pc, exp_pc);
      check({pair_wr, sreg_wr, push_valid}, stb);
   endtask

   // APB read or write; the request stands until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Test of a negative value: S is left alone, C kept
   task automatic t_test();
      @(posedge clock);
      rd_val <= 8'h80;
      sreg_in <= 8'h0B;
      pc_in <= 16'h0040;
      run_op(OP_SELF_AND_TEST, 1, 16'h0041, 3'b010);
      check(sreg_out, 8'h05);
   endtask

   // All six multiplies on extreme operands, plus a zero product
   task automatic t_mul();
      cmbse_op_e ops[7] = '{OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
         OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT,
         OP_UNSIGNED_PRODUCT};
      logic [15:0] prod[7] = '{16'hFE01, 16'h0001, 16'hFF01, 16'hFC02, 16'h0002, 16'hFE02, 16'h0000};
      logic [7:0] flg[7] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h02};
      for (int k = 0; k < 7; k++) begin
         @(posedge clock);
         rd_val <= (k == 6) ? 8'h00 : 8'hFF;
         rr_val <= (k == 6) ? 8'h12 : 8'hFF;
         sreg_in <= 8'h00;
         pc_in <= 16'h0010;
         run_op(ops[k], 2, 16'h0011, 3'b110);
         check(pair_result, prod[k]);
         check(sreg_out, flg[k]);
      end
   endtask

   // Pointer jump, relative invoke backwards, absolute jump and invoke
   task automatic t_flow();
      @(posedge clock);
      z_ptr <= 16'h1234;
      pc_in <= 16'h0100;
      imm <= 16'hFFF0;
      sreg_in <= 8'hFF;
      run_op(OP_POINTER_JUMP, 2, 16'h1234, 3'b000);
      run_op(OP_RELATIVE_INVOKE, 3, 16'h00F1, 3'b001);
      check(push_addr, 16'h0101);
      @(posedge clock);
      imm <= 16'h2000;
      run_op(OP_ABSOLUTE_JUMP, 3, 16'h2000, 3'b000);
      run_op(OP_ABSOLUTE_INVOKE, 4, 16'h2000, 3'b001);
      check(push_addr, 16'h0102);
   endtask

   // Compares; S is masked since only Z N V C H are defined here
   task automatic t_cmp();
      cmbse_op_e ops[5] = '{OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_CARRY, OP_COMPARE_CARRY,
         OP_COMPARE_IMMEDIATE};
      logic [7:0] a[5] = '{8'h10, 8'h05, 8'h05, 8'h05, 8'h7F};
      logic [7:0] b[5] = '{8'h20, 8'h05, 8'h04, 8'h04, 8'hFF};
      logic [7:0] s[5] = '{8'hC0, 8'hC1, 8'hC3, 8'hC1, 8'hC0};
      logic [7:0] e[5] = '{8'hC5, 8'hE5, 8'hC2, 8'hC0, 8'hCD};
      for (int k = 0; k < 5; k++) begin
         @(posedge clock);
         rd_val <= a[k];
         rr_val <= b[k];
         sreg_in <= s[k];
         pc_in <= 16'h0030;
         run_op(ops[k], 1, 16'h0031, 3'b010);
         check(sreg_out & 8'hEF, e[k]);
      end
   endtask

   // Compare-skip on match over one- and two-word followers, and on mismatch
   task automatic t_compare_skip_equal();
      logic [7:0] b[3] = '{8'h11, 8'h11, 8'h12};
      int c[3] = '{2, 3, 1};
      logic [15:0] p[3] = '{16'h0052, 16'h0053, 16'h0051};
      for (int k = 0; k < 3; k++) begin
         @(posedge clock);
         rd_val <= 8'h11;
         rr_val <= b[k];
         next_two_word <= (k != 0);
         pc_in <= 16'h0050;
         run_op(OP_COMPARE_SKIP_EQUAL, c[k], p[k], 3'b000);
      end
   endtask

   // Bit skips; the unselected source carries the opposite bit to catch a swapped source
   task automatic t_skip();
      cmbse_op_e op;
      logic [7:0] v;
      logic set;
      int c;
      for (int k = OP_SKIP_REG_BIT_CLEAR; k <= OP_SKIP_IO_BIT_SET; k++) begin
         for (int j = 0; j < 2; j++) begin
            op = cmbse_op_e'(k);
            v = j ? 8'hDF : 8'h20;
            set = (op == OP_SKIP_REG_BIT_SET || op == OP_SKIP_IO_BIT_SET);
            c = (v[5] == set) ? (v[0] ? 3 : 2) : 1;
            @(posedge clock);
            rr_val <= (k < OP_SKIP_IO_BIT_CLEAR) ? v : ~v;
            io_val <= (k < OP_SKIP_IO_BIT_CLEAR) ? ~v : v;
            bit_sel <= 3'h5;
            next_two_word <= v[0];
            pc_in <= 16'h0060;
            run_op(op, c, 16'h0060 + c[15:0], 3'b000);
         end
      end
   endtask

   function automatic logic taken(input cmbse_op_e op, input logic [7:0] s, input logic [2:0] b);
      case (op)
         OP_BRANCH_FLAG_SET: return s[b];
         OP_BRANCH_FLAG_CLEAR: return !s[b];
         OP_BRANCH_SIGNED_GE: return !(s[2] ^ s[3]);
         OP_BRANCH_SIGNED_LESS: return s[2] ^ s[3];
         OP_BRANCH_UNSIGNED_GE: return !s[0];
         OP_BRANCH_UNSIGNED_LESS: return s[0];
         OP_BRANCH_HALFCARRY_SET: return s[5];
         OP_BRANCH_HALFCARRY_CLEAR: return !s[5];
         OP_BRANCH_IRQ_ON: return s[7];
         OP_BRANCH_IRQ_OFF: return !s[7];
         OP_BRANCH_OVERFLOW_SET: return s[3];
         OP_BRANCH_OVERFLOW_CLEAR: return !s[3];
         OP_BRANCH_TRANSFER_SET: return s[6];
         OP_BRANCH_TRANSFER_CLEAR: return !s[6];
         OP_BRANCH_CARRY_SET: return s[0];
         default: return !s[0];
      endcase
   endfunction

   // Every flag branch against four flag patterns, status bit rotating for the generic pair
   task automatic t_branch();
      logic [7:0] pat[4] = '{8'h00, 8'hFF, 8'h04, 8'h0C};
      logic t;
      int n;
      n = 0;
      for (int k = OP_BRANCH_FLAG_SET; k <= OP_BRANCH_CARRY_CLEAR; k++) begin
         for (int j = 0; j < 4; j++) begin
            t = taken(cmbse_op_e'(k), pat[j], n[2:0]);
            @(posedge clock);
            sreg_in <= pat[j];
            bit_sel <= n[2:0];
            imm <= 16'h0010;
            pc_in <= 16'h0200;
            run_op(cmbse_op_e'(k), t ? 2 : 1, t ? 16'h0211 : 16'h0201, 3'b000);
            n++;
         end
      end
   endtask

   // Register reset values, read-only count, unmapped address, enable gating issue
   task automatic t_regs();
      apb(1'b0, `CMBSE_REG_CTRL, 32'h0);
      check(rdata, 32'h1);
      check(rerr, 1'b0);
      apb(1'b1, `CMBSE_REG_COUNT, 32'hFF);
      apb(1'b0, `CMBSE_REG_COUNT, 32'h0);
      check(rdata, n_ops);
      apb(1'b0, `CMBSE_REG_STATUS, 32'h0);
      check(rdata, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      check(rerr, 1'b1);
      check(rdata, 32'h0);
      apb(1'b1, `CMBSE_REG_CTRL, 32'h0);
      repeat (2) @(posedge clock);
      #1;
      check(issue_ready, 1'b0);
      apb(1'b1, `CMBSE_REG_CTRL, 32'h1);
      t_test();
   endtask

   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      t_test();
      t_mul();
      t_flow();
      t_cmp();
      t_compare_skip_equal();
      t_skip();
      t_branch();
      t_regs();
      summarize();
   end
endmodule // tb

`default_nettype wire
